// ==== pfp_pkg.sv ====
// package: register map, field layout and decoded field carrier
package pfp_pkg;

  localparam int          PORT_COUNT    = 20;
  localparam int          ADDR_W        = 12;

  localparam logic [11:0] CFG_BASE      = 12'h000;
  localparam logic [11:0] DATA_BASE     = 12'h080;
  localparam logic [11:0] MAP_SPAN      = 12'h050;

  localparam int          PARTNER_LSB   = 0;
  localparam int          PARTNER_W     = 5;
  localparam int          SAMPLES_LSB   = 5;
  localparam int          SAMPLES_W     = 3;
  localparam int          RANGE_LSB     = 8;
  localparam int          RANGE_W       = 3;
  localparam int          PARAM_W       = 12;
  localparam int          MODE_LSB      = 12;
  localparam int          MODE_W        = 4;
  localparam int          CFG_W         = 16;
  localparam int          BAD_RANGE_BIT = 16;

  localparam logic [15:0] CFG_RESET     = 16'h0000;
  localparam logic [2:0]  RANGE_NONE    = 3'h0;

  // one bit per mode code
  localparam logic [15:0] PAIRED_MODES  = 16'h0910;
  localparam logic [15:0] ADC_MODES     = 16'h0780;
  localparam logic [15:0] DAC_MODES     = 16'h0022;

  localparam int          ACC_W         = 19;
  localparam int          DATA_W        = 12;

  typedef struct packed {
    logic                 partner_valid;
    logic [PARTNER_W-1:0] partner;
    logic                 adc_en;
    logic [SAMPLES_W-1:0] avg_exp;
    logic [RANGE_W-1:0]   adc_range;
    logic [RANGE_W-1:0]   dac_range;
  } pfp_decode_s;

endpackage

// ==== pfp_averager.sv ====
// file: per-port sample averager with result register
`timescale 1ns/1ps

module pfp_averager (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  // control
  input  wire logic        clear_in,
  input  wire logic        enable_in,
  input  wire logic [2:0]  exp_in,
  // samples
  input  wire logic        sample_valid_in,
  input  wire logic [11:0] sample_in,
  // result
  output logic      [11:0] data_out,
  output logic             done_out
);

  logic [pfp_pkg::ACC_W-1:0] acc_reg;
  logic [7:0]                cnt_reg;
  logic [pfp_pkg::ACC_W-1:0] sum;
  logic [pfp_pkg::ACC_W-1:0] avg;
  logic [8:0]                target;
  logic                      last;
  logic                      take;

  assign take   = sample_valid_in && enable_in && !clear_in;
  assign sum    = acc_reg + {7'h00, sample_in};
  assign avg    = sum >> exp_in;
  assign target = 9'h001 << exp_in;
  assign last   = ({1'b0, cnt_reg} + 9'h001) == target;

  // accumulate until the selected count is reached
  always_ff @(posedge core_clk_in) begin
    if (reset_in || clear_in || !enable_in) begin
      acc_reg <= '0;
      cnt_reg <= 8'h00;
    end else if (take) begin
      acc_reg <= last ? '0 : sum;
      cnt_reg <= last ? 8'h00 : cnt_reg + 8'h01;
    end
  end

  // store only the averaged value
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      data_out <= 12'h000;
      done_out <= 1'b0;
    end else begin
      done_out <= take && last;
      if (take && last) begin
        data_out <= avg[pfp_pkg::DATA_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [8:0] seen_reg;
  always_ff @(posedge core_clk_in) begin
    if (reset_in || clear_in || !enable_in || (take && last)) begin
      seen_reg <= 9'h000;
    end else if (take) begin
      seen_reg <= seen_reg + 9'h001;
    end
  end

  a_avg_count: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    (take && last) |-> (seen_reg + 9'h001 == target))
    else $error("average stored after wrong sample count");

  a_avg_only_done: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    !$past(take && last) |-> $stable(data_out))
    else $error("data register changed without full average");

  c_avg_128: cover property (
    @(posedge core_clk_in) disable iff (reset_in)
    take && last && exp_in == 3'h7);

endmodule

// ==== pfp_port_params.sv ====
// design: function-parameter registers, field decode and averaging
// Behaviour
// - partner port comes from bits 4:0 when mode is 4, 8 or 11.
// - adc modes average the selected sample count before storing data.
// - sample field n means two to the n, 1 up to 128 samples.
// - bits 10:8 set input range in input modes, output range in output.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps

module pfp_port_params (
  // clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  reset_in,
  // apb slave
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [11:0]           paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // converter samples
  input  wire logic                  sample_valid_in,
  input  wire logic [4:0]            sample_port_in,
  input  wire logic [11:0]           sample_data_in,
  // decoded fields toward port logic
  output pfp_pkg::pfp_decode_s [19:0] decode_out,
  output logic      [19:0]           result_done_out
);

  localparam int N = pfp_pkg::PORT_COUNT;

  ////////////////////////////////////////////////////////////////////////////
  // configuration storage and decode
  logic [pfp_pkg::CFG_W-1:0]  cfg_reg [N];
  logic [N-1:0]               clear_reg;
  logic [11:0]                adc_data [N];
  logic [N-1:0]               done;
  logic [N-1:0]               paired;
  logic [N-1:0]               adc_mode;
  logic [N-1:0]               dac_mode;
  logic [N-1:0]               bad_range;
  pfp_pkg::pfp_decode_s [N-1:0] decode_next;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      paired[i]    = pfp_pkg::PAIRED_MODES[cfg_reg[i][pfp_pkg::MODE_LSB +:
                     pfp_pkg::MODE_W]];
      adc_mode[i]  = pfp_pkg::ADC_MODES[cfg_reg[i][pfp_pkg::MODE_LSB +:
                     pfp_pkg::MODE_W]];
      dac_mode[i]  = pfp_pkg::DAC_MODES[cfg_reg[i][pfp_pkg::MODE_LSB +:
                     pfp_pkg::MODE_W]];
      bad_range[i] = (adc_mode[i] || dac_mode[i]) &&
                     cfg_reg[i][pfp_pkg::RANGE_LSB +: pfp_pkg::RANGE_W] ==
                     pfp_pkg::RANGE_NONE;
      decode_next[i].partner_valid = paired[i];
      decode_next[i].partner = paired[i] ?
        cfg_reg[i][pfp_pkg::PARTNER_LSB +: pfp_pkg::PARTNER_W] :
        5'h00;
      decode_next[i].adc_en  = adc_mode[i];
      decode_next[i].avg_exp = adc_mode[i] ?
        cfg_reg[i][pfp_pkg::SAMPLES_LSB +: pfp_pkg::SAMPLES_W] :
        3'h0;
      decode_next[i].adc_range = adc_mode[i] ?
        cfg_reg[i][pfp_pkg::RANGE_LSB +: pfp_pkg::RANGE_W] :
        3'h0;
      decode_next[i].dac_range = dac_mode[i] ?
        cfg_reg[i][pfp_pkg::RANGE_LSB +: pfp_pkg::RANGE_W] :
        3'h0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      decode_out      <= '0;
      result_done_out <= '0;
    end else begin
      decode_out      <= decode_next;
      result_done_out <= done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic        setup;
  logic        access;
  logic        is_cfg;
  logic        is_data;
  logic [4:0]  idx;
  logic [11:0] off;
  logic        aligned;

  assign setup   = psel_in && !penable_in;
  assign access  = psel_in && penable_in && pready_out;
  assign aligned = paddr_in[1:0] == 2'h0;
  assign is_cfg  = aligned && paddr_in >= pfp_pkg::CFG_BASE &&
                   paddr_in < pfp_pkg::CFG_BASE + pfp_pkg::MAP_SPAN;
  assign is_data = aligned && paddr_in >= pfp_pkg::DATA_BASE &&
                   paddr_in < pfp_pkg::DATA_BASE + pfp_pkg::MAP_SPAN;
  assign off     = is_data ? paddr_in - pfp_pkg::DATA_BASE :
                   paddr_in - pfp_pkg::CFG_BASE;
  assign idx     = off[6:2];

  // one wait-free answer: ready in the first access cycle
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup && !(is_cfg || (is_data && !pwrite_in));
      if (setup && !pwrite_in) begin
        if (is_cfg) begin
          prdata_out <= {15'h0000, bad_range[idx], cfg_reg[idx]};
        end else if (is_data) begin
          prdata_out <= {20'h00000, adc_data[idx]};
        end else begin
          prdata_out <= 32'h0000_0000;
        end
      end
    end
  end

  // config writes; a rewrite restarts that port's average
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < N; i++) begin
        cfg_reg[i] <= pfp_pkg::CFG_RESET;
      end
      clear_reg <= '0;
    end else begin
      clear_reg <= '0;
      if (access && pwrite_in && is_cfg) begin
        cfg_reg[idx]   <= pwdata_in[pfp_pkg::CFG_W-1:0];
        clear_reg[idx] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port averagers
  for (genvar g = 0; g < N; g++) begin : g_port
    pfp_averager u_avg (
      .core_clk_in     (core_clk_in),
      .reset_in        (reset_in),
      .clear_in        (clear_reg[g]),
      .enable_in       (adc_mode[g]),
      .exp_in          (cfg_reg[g][pfp_pkg::SAMPLES_LSB +:
                        pfp_pkg::SAMPLES_W]),
      .sample_valid_in (sample_valid_in && sample_port_in == 5'(g)),
      .sample_in       (sample_data_in),
      .data_out        (adc_data[g]),
      .done_out        (done[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  for (genvar g = 0; g < N; g++) begin : g_chk
    a_partner_use: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      paired[g] |=> decode_out[g].partner_valid &&
        decode_out[g].partner == $past(cfg_reg[g][4:0]))
      else $error("partner port not taken in paired mode");

    a_partner_ignore: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      !paired[g] |=> !decode_out[g].partner_valid &&
        decode_out[g].partner == 5'h00)
      else $error("partner port used outside paired mode");

    a_range_route: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      adc_mode[g] |=> decode_out[g].adc_range == $past(cfg_reg[g][10:8])
        && decode_out[g].avg_exp == $past(cfg_reg[g][7:5]))
      else $error("input range or sample field not routed");

    a_samples_ignore: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      !adc_mode[g] && !clear_reg[g] |->
        !done[g] ##1 decode_out[g].avg_exp == 3'h0)
      else $error("sample count used without adc mode");
  end

  a_apb_ready: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    setup |=> pready_out ##1 !pready_out || setup)
    else $error("ready not a single access-cycle pulse");

  c_paired_write: cover property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && pwrite_in && is_cfg && pwdata_in[15:12] == 4'hB);

  c_data_read: cover property (
    @(posedge core_clk_in) disable iff (reset_in)
    access && !pwrite_in && is_data);

  c_slverr: cover property (
    @(posedge core_clk_in) disable iff (reset_in)
    pready_out && pslverr_out);

endmodule

// ==== pfp_port_params_tb_top.sv ====
// testbench: apb access, field decode and sample averaging
`timescale 1ns/1ps

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  bad_count++; $display("unexpected at %0t: got %h expected %h", \
  $time, got, exp); end end

module pfp_port_params_tb_top;
  logic                        core_clk_in;
  logic                        reset_in;
  logic                        psel_in;
  logic                        penable_in;
  logic                        pwrite_in;
  logic [11:0]                 paddr_in;
  logic [31:0]                 pwdata_in;
  logic [31:0]                 prdata_out;
  logic                        pready_out;
  logic                        pslverr_out;
  logic                        sample_valid_in;
  logic [4:0]                  sample_port_in;
  logic [11:0]                 sample_data_in;
  pfp_pkg::pfp_decode_s [19:0] decode_out;
  logic [19:0]                 result_done_out;
  int                          bad_count;
  int                          check_count;
  logic [31:0]                 rd;
  logic                        err;
  logic [18:0]                 sum;

  pfp_port_params pfp_port_params_i (
    .core_clk_in     (core_clk_in),
    .reset_in        (reset_in),
    .psel_in         (psel_in),
    .penable_in      (penable_in),
    .pwrite_in       (pwrite_in),
    .paddr_in        (paddr_in),
    .pwdata_in       (pwdata_in),
    .prdata_out      (prdata_out),
    .pready_out      (pready_out),
    .pslverr_out     (pslverr_out),
    .sample_valid_in (sample_valid_in),
    .sample_port_in  (sample_port_in),
    .sample_data_in  (sample_data_in),
    .decode_out      (decode_out),
    .result_done_out (result_done_out)
  );

  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge core_clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk_in);
      if (pready_out === 1'b1) break;
    end
    if (n == 20) begin
      bad_count++;
      conclude();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic cfg(input logic [4:0] p, input logic [3:0] m,
                     input logic [2:0] r, input logic [2:0] s);
    apb(1'b1, 12'(p) << 2, {16'h0000, m, 1'b0, r, s, 5'h13});
    repeat (2) @(posedge core_clk_in);
  endtask

  // feeds cnt samples back to back, returns their sum
  task automatic feed(input logic [4:0] p, input int cnt);
    sum = '0;
    for (int i = 0; i < cnt; i++) begin
      @(posedge core_clk_in);
      sample_valid_in <= 1'b1;
      sample_port_in  <= p;
      sample_data_in  <= 12'hF00 + 12'(i);
      sum += 19'(12'hF00 + 12'(i));
    end
    @(posedge core_clk_in);
    sample_valid_in <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_decode();
    logic [3:0] modes [6] = '{4'h4, 4'h8, 4'hB, 4'h0, 4'h7, 4'h5};
    logic [3:0] m;
    for (int k = 0; k < 6; k++) begin
      m = modes[k];
      cfg(5'h03, m, 3'h3, 3'h6);
      `CHK(decode_out[3].partner_valid, pfp_pkg::PAIRED_MODES[m])
      `CHK(decode_out[3].partner, pfp_pkg::PAIRED_MODES[m] ? 5'h13 : 5'h00)
      `CHK(decode_out[3].adc_en, pfp_pkg::ADC_MODES[m])
      `CHK(decode_out[3].avg_exp, pfp_pkg::ADC_MODES[m] ? 3'h6 : 3'h0)
      `CHK(decode_out[3].adc_range, pfp_pkg::ADC_MODES[m] ? 3'h3 : 3'h0)
      `CHK(decode_out[3].dac_range, pfp_pkg::DAC_MODES[m] ? 3'h3 : 3'h0)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK(rd[15:0], {m, 12'h3D3})
    end
  endtask

  task automatic t_flag();
    cfg(5'h06, 4'h7, 3'h0, 3'h0);
    apb(1'b0, 12'h018, 32'h0);
    `CHK(rd[16], 1'b1)
    cfg(5'h06, 4'h7, 3'h1, 3'h0);
    apb(1'b0, 12'h018, 32'h0);
    `CHK(rd[16], 1'b0)
  endtask

  task automatic t_avg();
    int w;
    for (int n = 0; n < 8; n++) begin
      cfg(5'h02, 4'h7, 3'h1, 3'(n));
      feed(5'h02, 1 << n);
      for (w = 0; w < 8; w++) begin
        @(posedge core_clk_in);
        if (result_done_out[2] === 1'b1) break;
      end
      if (w == 8) begin
        bad_count++;
        conclude();
      end
      `CHK(w, 1)
      apb(1'b0, 12'h088, 32'h0);
      `CHK(rd[11:0], 12'(sum >> n))
      `CHK(err, 1'b0)
    end
  endtask

  task automatic t_ignore();
    cfg(5'h04, 4'h5, 3'h1, 3'h3);
    feed(5'h04, 8);
    repeat (4) begin
      @(posedge core_clk_in);
      `CHK(result_done_out[4], 1'b0)
    end
    apb(1'b0, 12'h090, 32'h0);
    `CHK(rd, 32'h0)
  endtask

  task automatic t_refuse();
    apb(1'b0, 12'h050, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, 12'h088, 32'h5);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h002, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h088, 32'h0);
    `CHK(rd[11:0], 12'hF3F)
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    check_count = 0;
    reset_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    sample_valid_in = 1'b0;
    sample_port_in = 5'h00;
    sample_data_in = 12'h000;
    repeat (5) @(posedge core_clk_in);
    reset_in <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(decode_out, '0)
    t_decode();
    t_flag();
    t_avg();
    t_ignore();
    t_refuse();
    conclude();
  end
endmodule
